// File: design/sdram_command_decoder.sv
// Function
// - termination on when input high and enabled, outside self refresh
// - ignore termination input when setting disabled
// - reset low active, asynchronous
// - eight banks, 13-bit row, 10-bit column
// - activate loads one 2KB page per bank
// - bit ten autoprecharge, bit twelve burst length
// - decode all inputs at one clock edge
// - clock-enable edges make power transitions
// - precharge one bank or all by bit ten
// - calibration long or short by bit ten
// - fixed-length write ignores bit twelve
// - on-the-fly write: twelve low chops to four
// - write with bit ten closes bank after
// - fixed-length read ignores bit twelve
// - on-the-fly read: twelve low chops to four
// - read with bit ten closes bank after
// - mode set writes opcode to selected register
// - select high masks every command but power-down entry and power exits
`timescale 1ns/1ps
`default_nettype none
module sdram_command_decoder #(
  parameter int BANK_BITS = sdram_cmd_pkg::BANK_BITS,
  parameter int ROW_BITS  = sdram_cmd_pkg::ROW_BITS,
  parameter int COL_BITS  = sdram_cmd_pkg::COL_BITS
) (
  input  wire logic                 CLK,
  input  wire logic                 ARST_N,
  input  wire logic                 CKE,
  input  wire logic                 SELECT_N,
  input  wire logic                 ROW_STROBE_N,
  input  wire logic                 COL_STROBE_N,
  input  wire logic                 WRITE_EN_N,
  input  wire logic [BANK_BITS-1:0] BANK_SELECT,
  input  wire logic [ROW_BITS-1:0]  ADDR,
  input  wire logic                 TERMINATION_ENABLE,
  output var  logic [4:0]           CMD,
  output var  logic                 CMD_VALID,
  output var  logic [BANK_BITS-1:0] CMD_BANK,
  output var  logic [ROW_BITS-1:0]  CMD_ROW,
  output var  logic [COL_BITS-1:0]  CMD_COL,
  output var  logic                 CMD_CHOP,
  output var  logic                 CMD_AUTO_CLOSE,
  output var  logic [7:0]           OPEN_BANKS,
  output var  logic [ROW_BITS-1:0]  OPEN_ROW [8],
  output var  logic [1:0]           POWER_STATE,
  output var  logic                 TERM_ON,
  output var  logic [12:0]          MODE_REG [4]
);

  // ------------------------------------------------------------------
  // input decode
  // ------------------------------------------------------------------
  logic cke_prev_reg;
  sdram_cmd_pkg::pwr_t pwr_reg;
  sdram_cmd_pkg::pwr_t pwr_next;

  wire cke_fall = cke_prev_reg & ~CKE;
  wire cke_rise = ~cke_prev_reg & CKE;
  wire cke_hold = cke_prev_reg & CKE;
  wire [2:0] strobes = {ROW_STROBE_N, COL_STROBE_N, WRITE_EN_N};
  wire idle_code = SELECT_N | (strobes == 3'h7);
  wire ap_bit = ADDR[sdram_cmd_pkg::AP_POS];
  wire bc_bit = ADDR[sdram_cmd_pkg::BC_POS];

  function automatic logic [4:0] decode_cmd(input logic sel_n, input logic [2:0] s,
                                           input logic ap);
    logic [4:0] c;
    c = sdram_cmd_pkg::CMD_ILLEGAL;
    if (sel_n) begin
      c = sdram_cmd_pkg::CMD_DESELECT;
    end else begin
      unique case (s)
        3'h0: c = sdram_cmd_pkg::CMD_MODE_SET;
        3'h1: c = sdram_cmd_pkg::CMD_REFRESH;
        3'h2: c = ap ? sdram_cmd_pkg::CMD_PRE_ALL : sdram_cmd_pkg::CMD_PRE_ONE;
        3'h3: c = sdram_cmd_pkg::CMD_ROW_OPEN;
        3'h4: c = ap ? sdram_cmd_pkg::CMD_WRITE_AUTO : sdram_cmd_pkg::CMD_WRITE;
        3'h5: c = ap ? sdram_cmd_pkg::CMD_READ_AUTO : sdram_cmd_pkg::CMD_READ;
        3'h6: c = ap ? sdram_cmd_pkg::CMD_CAL_LONG : sdram_cmd_pkg::CMD_CAL_SHORT;
        3'h7: c = sdram_cmd_pkg::CMD_NOP;
      endcase
    end
    return c;
  endfunction : decode_cmd

  wire [4:0] plain_cmd = decode_cmd(SELECT_N, strobes, ap_bit);

  // clock-enable transitions select power entry and exit
  // a rise while active follows reset release or a refused entry and is no exit
  logic [4:0] cmd_next;
  always_comb begin
    cmd_next = sdram_cmd_pkg::CMD_ILLEGAL;
    pwr_next = pwr_reg;
    if (cke_hold && pwr_reg == sdram_cmd_pkg::PWR_ACTIVE) begin
      cmd_next = plain_cmd;
    end else if (cke_fall && pwr_reg == sdram_cmd_pkg::PWR_ACTIVE) begin
      if (!SELECT_N && strobes == 3'h1) begin
        cmd_next = sdram_cmd_pkg::CMD_SELF_ENTRY;
        pwr_next = sdram_cmd_pkg::PWR_SELF;
      end else if (idle_code) begin
        cmd_next = sdram_cmd_pkg::CMD_PD_ENTRY;
        pwr_next = sdram_cmd_pkg::PWR_DOWN;
      end
    end else if (cke_rise && idle_code && pwr_reg != sdram_cmd_pkg::PWR_ACTIVE) begin
      if (pwr_reg == sdram_cmd_pkg::PWR_SELF) begin
        cmd_next = sdram_cmd_pkg::CMD_SELF_EXIT;
      end else begin
        cmd_next = sdram_cmd_pkg::CMD_PD_EXIT;
      end
      pwr_next = sdram_cmd_pkg::PWR_ACTIVE;
    end else if (!CKE) begin
      cmd_next = sdram_cmd_pkg::CMD_DESELECT;
    end
  end

  wire cmd_valid_next = (cmd_next != sdram_cmd_pkg::CMD_DESELECT)
                        && (cmd_next != sdram_cmd_pkg::CMD_NOP)
                        && (cmd_next != sdram_cmd_pkg::CMD_ILLEGAL);

  // ------------------------------------------------------------------
  // mode registers
  // ------------------------------------------------------------------
  wire mr_write = (cmd_next == sdram_cmd_pkg::CMD_MODE_SET);

  sdram_mode_regs #(
    .WIDTH (13),
    .COUNT (sdram_cmd_pkg::MR_COUNT)
  ) sdram_mode_regs_inst (
    .CLK     (CLK),
    .ARST_N  (ARST_N),
    .wr_en   (mr_write),
    .wr_sel  (BANK_SELECT[1:0]),
    .wr_data (ADDR),
    .mr_flat (MODE_REG)
  );

  wire [1:0] bl_mode = MODE_REG[0][sdram_cmd_pkg::MR0_BL_LSB +: 2];
  wire is_rw = !SELECT_N && !COL_STROBE_N && ROW_STROBE_N;
  // fixed modes ignore bit twelve, on-the-fly low bit twelve chops
  wire chop_next = (bl_mode == sdram_cmd_pkg::MR0_BL_OTF) ? ~bc_bit
                 : (bl_mode == sdram_cmd_pkg::MR0_BL_FIXED4);

  // ------------------------------------------------------------------
  // termination
  // ------------------------------------------------------------------
  wire rtt_nom_on = MODE_REG[1][sdram_cmd_pkg::MR1_RTT_B0]
                  | MODE_REG[1][sdram_cmd_pkg::MR1_RTT_B1]
                  | MODE_REG[1][sdram_cmd_pkg::MR1_RTT_B2];
  wire rtt_wr_on = |MODE_REG[2][sdram_cmd_pkg::MR2_RTTWR_LSB +: 2];
  wire rtt_any = rtt_nom_on | rtt_wr_on;
  wire term_next = TERMINATION_ENABLE & rtt_any
                 & (pwr_next != sdram_cmd_pkg::PWR_SELF);

  // ------------------------------------------------------------------
  // bank state
  // ------------------------------------------------------------------
  logic [7:0] open_next;
  always_comb begin
    open_next = OPEN_BANKS;
    unique case (cmd_next)
      sdram_cmd_pkg::CMD_ROW_OPEN:   open_next[BANK_SELECT] = 1'b1;
      sdram_cmd_pkg::CMD_PRE_ONE:    open_next[BANK_SELECT] = 1'b0;
      sdram_cmd_pkg::CMD_PRE_ALL:    open_next = 8'h00;
      sdram_cmd_pkg::CMD_WRITE_AUTO: open_next[BANK_SELECT] = 1'b0;
      sdram_cmd_pkg::CMD_READ_AUTO:  open_next[BANK_SELECT] = 1'b0;
      default:                       open_next = OPEN_BANKS;
    endcase
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cke_prev_reg <= 1'b0;
      pwr_reg      <= sdram_cmd_pkg::PWR_ACTIVE;
      OPEN_BANKS   <= 8'h00;
      TERM_ON      <= 1'b0;
    end else begin
      cke_prev_reg <= CKE;
      pwr_reg      <= pwr_next;
      OPEN_BANKS   <= open_next;
      TERM_ON      <= term_next;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CMD            <= sdram_cmd_pkg::CMD_DESELECT;
      CMD_VALID      <= 1'b0;
      CMD_BANK       <= '0;
      CMD_ROW        <= '0;
      CMD_COL        <= '0;
      CMD_CHOP       <= 1'b0;
      CMD_AUTO_CLOSE <= 1'b0;
    end else begin
      CMD            <= cmd_next;
      CMD_VALID      <= cmd_valid_next;
      CMD_BANK       <= BANK_SELECT;
      CMD_ROW        <= ADDR;
      CMD_COL        <= ADDR[COL_BITS-1:0];
      CMD_CHOP       <= is_rw & chop_next;
      CMD_AUTO_CLOSE <= is_rw & ap_bit;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < 8; i++) begin
        OPEN_ROW[i] <= '0;
      end
    end else if (cmd_next == sdram_cmd_pkg::CMD_ROW_OPEN) begin
      OPEN_ROW[BANK_SELECT] <= ADDR;
    end
  end

  assign POWER_STATE = pwr_reg;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  a_deselect_masks: assert property (@(posedge CLK) disable iff (!ARST_N)
    (SELECT_N && cke_hold) |=> (CMD == sdram_cmd_pkg::CMD_DESELECT) && !CMD_VALID)
    else $error("select high not masked");

  a_activate_opens: assert property (@(posedge CLK) disable iff (!ARST_N)
    (cke_hold && pwr_reg == 2'h0 && !SELECT_N && strobes == 3'h3)
      |=> OPEN_BANKS[$past(BANK_SELECT)] && OPEN_ROW[$past(BANK_SELECT)] == $past(ADDR))
    else $error("activate did not open bank");

  a_precharge_all: assert property (@(posedge CLK) disable iff (!ARST_N)
    (cke_hold && pwr_reg == 2'h0 && !SELECT_N && strobes == 3'h2 && ap_bit)
      |=> OPEN_BANKS == 8'h00)
    else $error("precharge all left bank open");

  a_read_chop: assert property (@(posedge CLK) disable iff (!ARST_N)
    (cke_hold && !SELECT_N && strobes == 3'h5 && bl_mode == 2'h1)
      |=> CMD_CHOP == !$past(bc_bit))
    else $error("on-the-fly chop wrong");

  a_fixed_burst: assert property (@(posedge CLK) disable iff (!ARST_N)
    (cke_hold && !SELECT_N && strobes == 3'h4 && bl_mode == 2'h0) |=> !CMD_CHOP)
    else $error("fixed burst chopped");

  a_term_ignored: assert property (@(posedge CLK) disable iff (!ARST_N)
    !rtt_any |=> !TERM_ON)
    else $error("termination on while disabled");

  a_term_follows: assert property (@(posedge CLK) disable iff (!ARST_N)
    (TERMINATION_ENABLE && rtt_any && pwr_next == 2'h0) |=> TERM_ON)
    else $error("termination not enabled");

  a_self_entry: assert property (@(posedge CLK) disable iff (!ARST_N)
    (cke_fall && pwr_reg == 2'h0 && !SELECT_N && strobes == 3'h1)
      |=> POWER_STATE == 2'h2 ##1 (CKE || POWER_STATE == 2'h2))
    else $error("self refresh not entered");

  a_nop_keeps: assert property (@(posedge CLK) disable iff (!ARST_N)
    (cke_hold && idle_code) |=> $stable(OPEN_BANKS))
    else $error("idle command changed banks");

  a_exit_needs_low: assert property (@(posedge CLK) disable iff (!ARST_N)
    (cke_rise && pwr_reg == sdram_cmd_pkg::PWR_ACTIVE) |=> !CMD_VALID)
    else $error("clock-enable rise while active taken as a command");

  a_mode_write: assert property (@(posedge CLK) disable iff (!ARST_N)
    (cke_hold && pwr_reg == 2'h0 && !SELECT_N && strobes == 3'h0)
      |=> MODE_REG[$past(BANK_SELECT[1:0])] == $past(ADDR))
    else $error("mode register not written");

  a_precharge_one: assert property (@(posedge CLK) disable iff (!ARST_N)
    (cke_hold && pwr_reg == 2'h0 && !SELECT_N && strobes == 3'h2 && !ap_bit)
      |=> !OPEN_BANKS[$past(BANK_SELECT)])
    else $error("precharged bank left open");

  a_auto_close: assert property (@(posedge CLK) disable iff (!ARST_N)
    (cke_hold && pwr_reg == 2'h0 && !SELECT_N && ROW_STROBE_N && !COL_STROBE_N && ap_bit)
      |=> CMD_AUTO_CLOSE && !OPEN_BANKS[$past(BANK_SELECT)])
    else $error("auto precharge did not close bank");

  a_write_chop: assert property (@(posedge CLK) disable iff (!ARST_N)
    (cke_hold && !SELECT_N && strobes == 3'h4 && bl_mode == 2'h1)
      |=> CMD_CHOP == !$past(bc_bit))
    else $error("on-the-fly write chop wrong");

  a_fixed_four: assert property (@(posedge CLK) disable iff (!ARST_N)
    (cke_hold && !SELECT_N && ROW_STROBE_N && !COL_STROBE_N && bl_mode == 2'h2)
      |=> CMD_CHOP)
    else $error("fixed four-beat burst not chopped");

  a_refresh_keeps: assert property (@(posedge CLK) disable iff (!ARST_N)
    (cke_hold && pwr_reg == 2'h0 && !SELECT_N && strobes == 3'h1)
      |=> CMD == sdram_cmd_pkg::CMD_REFRESH && $stable(OPEN_BANKS))
    else $error("refresh decoded wrongly");

  a_column_addr: assert property (@(posedge CLK) disable iff (!ARST_N)
    (cke_hold && !SELECT_N && ROW_STROBE_N && !COL_STROBE_N)
      |=> CMD_COL == $past(ADDR[COL_BITS-1:0]) && CMD_BANK == $past(BANK_SELECT))
    else $error("column or bank not captured");

  a_cal_select: assert property (@(posedge CLK) disable iff (!ARST_N)
    (cke_hold && pwr_reg == 2'h0 && !SELECT_N && strobes == 3'h6)
      |=> CMD == ($past(ap_bit) ? sdram_cmd_pkg::CMD_CAL_LONG
                                : sdram_cmd_pkg::CMD_CAL_SHORT))
    else $error("calibration length wrong");

  a_self_no_term: assert property (@(posedge CLK) disable iff (!ARST_N)
    POWER_STATE == 2'h2 |-> !TERM_ON)
    else $error("termination on in self refresh");

endmodule : sdram_command_decoder
`default_nettype wire

// File: design/sdram_cmd_pkg.sv
package sdram_cmd_pkg;

  // ------------------------------------------------------------------
  // addressing
  // ------------------------------------------------------------------
  localparam int BANK_BITS   = 3;
  localparam int ROW_BITS    = 13;
  localparam int COL_BITS    = 10;
  localparam int DQ_BITS     = 16;
  localparam int NUM_BANKS   = 8;
  localparam int PAGE_BYTES  = (1 << COL_BITS) * DQ_BITS / 8;
  localparam int AP_POS      = 10;
  localparam int BC_POS      = 12;
  localparam int MR_COUNT    = 4;

  // ------------------------------------------------------------------
  // mode register fields used by this block
  // ------------------------------------------------------------------
  localparam int MR0_BL_LSB   = 0;
  localparam logic [1:0] MR0_BL_FIXED8 = 2'h0;
  localparam logic [1:0] MR0_BL_OTF    = 2'h1;
  localparam logic [1:0] MR0_BL_FIXED4 = 2'h2;
  localparam int MR1_RTT_B0  = 2;
  localparam int MR1_RTT_B1  = 6;
  localparam int MR1_RTT_B2  = 9;
  localparam int MR2_RTTWR_LSB = 9;
  localparam logic [12:0] MR_RESET_VALUE = 13'h0000;

  // ------------------------------------------------------------------
  // decoded commands
  // ------------------------------------------------------------------
  typedef enum logic [4:0] {
    CMD_DESELECT     = 5'h00,
    CMD_NOP          = 5'h01,
    CMD_MODE_SET     = 5'h02,
    CMD_REFRESH      = 5'h03,
    CMD_SELF_ENTRY   = 5'h04,
    CMD_SELF_EXIT    = 5'h05,
    CMD_PRE_ONE      = 5'h06,
    CMD_PRE_ALL      = 5'h07,
    CMD_ROW_OPEN     = 5'h08,
    CMD_WRITE        = 5'h09,
    CMD_WRITE_AUTO   = 5'h0A,
    CMD_READ         = 5'h0B,
    CMD_READ_AUTO    = 5'h0C,
    CMD_CAL_LONG     = 5'h0D,
    CMD_CAL_SHORT    = 5'h0E,
    CMD_PD_ENTRY     = 5'h0F,
    CMD_PD_EXIT      = 5'h10,
    CMD_ILLEGAL      = 5'h11
  } cmd_t;

  typedef enum logic [1:0] {
    PWR_ACTIVE  = 2'h0,
    PWR_DOWN    = 2'h1,
    PWR_SELF    = 2'h2
  } pwr_t;

endpackage : sdram_cmd_pkg

// File: design/sdram_mode_regs.sv
`timescale 1ns/1ps
`default_nettype none
module sdram_mode_regs #(
  parameter int WIDTH = 13,
  parameter int COUNT = 4
) (
  input  wire logic                     CLK,
  input  wire logic                     ARST_N,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(COUNT)-1:0] wr_sel,
  input  wire logic [WIDTH-1:0]         wr_data,
  output var  logic [WIDTH-1:0]         mr_flat [COUNT]
);

  logic [WIDTH-1:0] mem_reg [COUNT];

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < COUNT; i++) begin
        mem_reg[i] <= sdram_cmd_pkg::MR_RESET_VALUE;
      end
    end else if (wr_en) begin
      mem_reg[wr_sel] <= wr_data;
    end
  end

  always_comb begin
    for (int i = 0; i < COUNT; i++) begin
      mr_flat[i] = mem_reg[i];
    end
  end

endmodule : sdram_mode_regs
`default_nettype wire

// File: verification/ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
  input  wire logic        CLK,
  output var  logic        CKE,
  output var  logic        SELECT_N,
  output var  logic        ROW_STROBE_N,
  output var  logic        COL_STROBE_N,
  output var  logic        WRITE_EN_N,
  output var  logic [2:0]  BANK_SELECT,
  output var  logic [12:0] ADDR,
  output var  logic        TERMINATION_ENABLE
);
  initial begin
    CKE = 1'h1;
    {SELECT_N, ROW_STROBE_N, COL_STROBE_N, WRITE_EN_N} = 4'h7;
    BANK_SELECT = 3'h0;
    ADDR = 13'h0000;
    TERMINATION_ENABLE = 1'h0;
  end
  // ------------------------------------------------------------------
  // one command per call, lines hold until the next call
  // ------------------------------------------------------------------
  task automatic issue(input logic [3:0] code, input logic [2:0] ba, input logic [12:0] a,
                       input logic cke);
    {SELECT_N, ROW_STROBE_N, COL_STROBE_N, WRITE_EN_N} = code;
    CKE = cke;
    BANK_SELECT = ba;
    ADDR = a;
    @(posedge CLK);
    @(negedge CLK);
  endtask : issue
  task automatic idle();
    CKE = 1'h1;
    {SELECT_N, ROW_STROBE_N, COL_STROBE_N, WRITE_EN_N} = 4'h7;
  endtask : idle
  task automatic term_level(input logic level);
    TERMINATION_ENABLE = level;
  endtask : term_level
endmodule : ctrl_model
`default_nettype wire

// File: verification/sdram_command_decoder_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sdram_command_decoder_bench;
  logic clk, arst_n, cke, sel_n, ras_n, cas_n, we_n, term;
  logic [2:0] ba;
  logic [12:0] addr;
  logic [4:0] cmd;
  logic cvalid, chop, aclose, term_on;
  logic [2:0] cbank;
  logic [12:0] crow;
  logic [9:0] ccol;
  logic [7:0] open_banks;
  logic [12:0] open_row [8];
  logic [1:0] pstate;
  logic [12:0] mode_reg [4];
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  localparam logic [3:0] MODE_REGISTER_SET_CMD = 4'h0, REF = 4'h1, PRE = 4'h2, ACT = 4'h3;
  localparam logic [3:0] WR = 4'h4, RD = 4'h5, ZQ = 4'h6, NO_OPERATION_CMD = 4'h7, DES = 4'hB;

  ctrl_model ctrl_model_inst (.CLK(clk), .CKE(cke), .SELECT_N(sel_n), .ROW_STROBE_N(ras_n),
    .COL_STROBE_N(cas_n), .WRITE_EN_N(we_n), .BANK_SELECT(ba), .ADDR(addr),
    .TERMINATION_ENABLE(term));
  sdram_command_decoder sdram_command_decoder_inst (.CLK(clk), .ARST_N(arst_n), .CKE(cke),
    .SELECT_N(sel_n), .ROW_STROBE_N(ras_n), .COL_STROBE_N(cas_n), .WRITE_EN_N(we_n),
    .BANK_SELECT(ba), .ADDR(addr), .TERMINATION_ENABLE(term), .CMD(cmd), .CMD_VALID(cvalid),
    .CMD_BANK(cbank), .CMD_ROW(crow), .CMD_COL(ccol), .CMD_CHOP(chop),
    .CMD_AUTO_CLOSE(aclose), .OPEN_BANKS(open_banks), .OPEN_ROW(open_row),
    .POWER_STATE(pstate), .TERM_ON(term_on), .MODE_REG(mode_reg));

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      conclude();
    end
  end
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic go(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a);
    ctrl_model_inst.issue(c, b, a, 1'h1);
  endtask : go
  task automatic conclude();
    if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    ctrl_model_inst.idle();
    arst_n = 1'h0;
    #1;
    chk(open_banks, 0);
    chk(cmd, 0);
    chk(mode_reg[0], 0);
    repeat (12) @(negedge clk);
    arst_n = 1'h1;
    @(negedge clk);
    chk(cvalid, 0);
    repeat (2) @(negedge clk);
    chk(pstate, 0);
  endtask : t_reset
  task automatic t_activate();
    go(ACT, 3'h2, 13'h0005);
    chk(cmd, 5'h08);
    chk(cvalid, 1);
    chk(open_row[2], 13'h0005);
    chk(cbank, 3'h2);
    chk(crow, 13'h0005);
    go(ACT, 3'h7, 13'h1FFF);
    chk(open_row[7], 13'h1FFF);
    chk(open_banks, 8'h84);
  endtask : t_activate
  task automatic t_burst();
    go(MODE_REGISTER_SET_CMD, 3'h0, 13'h0001);
    chk(mode_reg[0], 13'h0001);
    go(RD, 3'h2, 13'h03FF);
    chk(cmd, 5'h0B);
    chk(chop, 1);
    chk(ccol, 10'h3FF);
    chk(aclose, 0);
    go(RD, 3'h2, 13'h1000);
    chk(chop, 0);
    go(WR, 3'h2, 13'h0000);
    chk(cmd, 5'h09);
    chk(chop, 1);
    go(WR, 3'h2, 13'h1000);
    chk(chop, 0);
    go(MODE_REGISTER_SET_CMD, 3'h0, 13'h0000);
    go(WR, 3'h2, 13'h0000);
    chk(chop, 0);
    go(RD, 3'h2, 13'h0000);
    chk(chop, 0);
    go(MODE_REGISTER_SET_CMD, 3'h0, 13'h0002);
    go(RD, 3'h2, 13'h1000);
    chk(chop, 1);
    go(WR, 3'h2, 13'h1000);
    chk(chop, 1);
    go(MODE_REGISTER_SET_CMD, 3'h0, 13'h0000);
  endtask : t_burst
  task automatic t_autoclose();
    go(WR, 3'h2, 13'h0400);
    chk(cmd, 5'h0A);
    chk(aclose, 1);
    chk(open_banks, 8'h80);
    go(ACT, 3'h2, 13'h0005);
    go(RD, 3'h2, 13'h1400);
    chk(cmd, 5'h0C);
    chk(open_banks, 8'h80);
  endtask : t_autoclose
  task automatic t_misc();
    go(ACT, 3'h3, 13'h0001);
    go(PRE, 3'h3, 13'h0000);
    chk(cmd, 5'h06);
    chk(open_banks, 8'h80);
    go(ACT, 3'h1, 13'h0002);
    go(DES, 3'h4, 13'h0009);
    chk(cmd, 5'h00);
    chk(open_banks, 8'h82);
    go(NO_OPERATION_CMD, 3'h4, 13'h0009);
    chk(cmd, 5'h01);
    chk(cvalid, 0);
    chk(open_banks, 8'h82);
    go(REF, 3'h5, 13'h1FFF);
    chk(cmd, 5'h03);
    chk(open_banks, 8'h82);
    go(ZQ, 3'h0, 13'h0400);
    chk(cmd, 5'h0D);
    go(ZQ, 3'h0, 13'h0000);
    chk(cmd, 5'h0E);
    go(PRE, 3'h0, 13'h0400);
    chk(cmd, 5'h07);
    chk(open_banks, 8'h00);
  endtask : t_misc
  task automatic t_term();
    go(MODE_REGISTER_SET_CMD, 3'h1, 13'h0004);
    ctrl_model_inst.term_level(1'h1);
    repeat (2) @(negedge clk);
    chk(term_on, 1);
    go(MODE_REGISTER_SET_CMD, 3'h1, 13'h0000);
    repeat (2) @(negedge clk);
    chk(term_on, 0);
    go(MODE_REGISTER_SET_CMD, 3'h2, 13'h0200);
    repeat (2) @(negedge clk);
    chk(term_on, 1);
    go(MODE_REGISTER_SET_CMD, 3'h2, 13'h0000);
    repeat (2) @(negedge clk);
    chk(term_on, 0);
    ctrl_model_inst.term_level(1'h0);
  endtask : t_term
  task automatic t_power();
    ctrl_model_inst.issue(NO_OPERATION_CMD, 3'h0, 13'h0000, 1'h0);
    chk(cmd, 5'h0F);
    chk(pstate, 1);
    go(NO_OPERATION_CMD, 3'h0, 13'h0000);
    chk(cmd, 5'h10);
    chk(pstate, 0);
    go(NO_OPERATION_CMD, 3'h0, 13'h0000);
    ctrl_model_inst.issue(REF, 3'h0, 13'h0000, 1'h0);
    chk(cmd, 5'h04);
    chk(pstate, 2);
    ctrl_model_inst.issue(ACT, 3'h4, 13'h0009, 1'h0);
    chk(cmd, 5'h00);
    chk(open_banks, 8'h00);
    go(NO_OPERATION_CMD, 3'h0, 13'h0000);
    chk(cmd, 5'h05);
    chk(pstate, 0);
    go(NO_OPERATION_CMD, 3'h0, 13'h0000);
  endtask : t_power

  initial begin
    arst_n = 1'h0;
    @(negedge clk);
    t_reset();
    t_activate();
    t_reset();
    t_activate();
    t_burst();
    t_autoclose();
    t_misc();
    t_term();
    t_power();
    conclude();
  end
endmodule : sdram_command_decoder_bench
`default_nettype wire
